// >>> rtl/cfg_group_pkg.sv
// Package: command codes, field layouts, reset values and carriers for the config group
package cfg_group_pkg;

   // Command codes
   localparam logic [7:0] CMD_SCALE_LOOP = 8'h29;
   localparam logic [7:0] CMD_OUTPUT_FLOOR = 8'h2B;
   localparam logic [7:0] CMD_SWITCHING_RATE = 8'h33;
   localparam logic [7:0] CMD_INPUT_TURN_ON = 8'h35;

   // Linear format field positions
   localparam int EXP_MSB = 15;
   localparam int EXP_LSB = 11;
   localparam int MAN_MSB = 10;
   localparam int MAN_LSB = 0;
   localparam int FIX_FRAC = 16;

   // Reset values
   localparam logic [4:0] SCALE_EXP_RESET = 5'h19;
   localparam logic [4:0] TURN_ON_EXP_RESET = 5'h1E;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam int LOAD_DELAY_CYCLES = 1;

   // Divider breakpoints, unsigned Q16
   localparam logic [47:0] FIX_EIGHTH = 48'h0000_0000_2000;
   localparam logic [47:0] FIX_QUARTER = 48'h0000_0000_4000;
   localparam logic [47:0] FIX_HALF = 48'h0000_0000_8000;
   localparam logic [47:0] FIX_ONE = 48'h0000_0001_0000;

   // Divider selection codes
   localparam logic [1:0] DIV_EIGHTH = 2'h0;
   localparam logic [1:0] DIV_QUARTER = 2'h1;
   localparam logic [1:0] DIV_HALF = 2'h2;
   localparam logic [1:0] DIV_ONE = 2'h3;

   // Switching rate bands: start of band i+1 and effective rate of band i
   localparam int RATE_BANDS = 12;
   localparam logic [10:0] RATE_BAND_START [RATE_BANDS-1] = '{
      11'd251, 11'd301, 11'd351, 11'd411, 11'd501, 11'd601,
      11'd701, 11'd821, 11'd1001, 11'd1201, 11'd1401};
   localparam logic [10:0] RATE_BAND_KHZ [RATE_BANDS] = '{
      11'd225, 11'd275, 11'd325, 11'd375, 11'd450, 11'd550,
      11'd650, 11'd750, 11'd900, 11'd1100, 11'd1300, 11'd1500};
   localparam logic [15:0] RATE_LIMIT_KHZ = 16'd1650;
   localparam logic [10:0] MAN_POS_MAX = 11'h3FF;

   // Turn-on hardware levels in quarter volts
   localparam logic [10:0] TURN_ON_HW_MIN_QV = 11'd10;
   localparam logic [10:0] TURN_ON_HW_MAX_QV = 11'd63;

   // Status bit positions
   localparam int SB_NONE_ABOVE = 0;
   localparam int SB_CML = 1;
   localparam int SW_VOUT = 15;
   localparam int SV_MAX_MIN_WARN = 3;
   localparam int SC_INVALID_CMD = 7;
   localparam int SC_INVALID_DATA = 6;

   typedef struct packed {
      logic write;
      logic [7:0] code;
      logic [15:0] data;
   } cmd_req_t;

   typedef struct packed {
      logic valid;
      logic error;
      logic [15:0] data;
   } cmd_rsp_t;

   typedef struct packed {
      logic [15:0] floor_word;
      logic [10:0] scale_man;
      logic [10:0] rate_khz;
      logic [10:0] turn_on_man;
   } nvm_cfg_t;

   typedef struct packed {
      logic [7:0] status_byte;
      logic [15:0] status_word;
      logic [7:0] status_vout;
      logic [7:0] status_cml;
   } status_t;

   // Linear word to signed Q16 fixed point
   function automatic logic signed [47:0] lin_fix(input logic [15:0] w);
      logic signed [5:0] e;
      logic signed [47:0] m;
      e = {w[EXP_MSB], w[EXP_MSB:EXP_LSB]};
      m = {{37{w[MAN_MSB]}}, w[MAN_MSB:MAN_LSB]};
      m = m <<< FIX_FRAC;
      if (e >= 0) begin
         lin_fix = m <<< $unsigned(e);
      end else begin
         lin_fix = m >>> $unsigned(-e);
      end
   endfunction : lin_fix

endpackage : cfg_group_pkg

// >>> rtl/pmbus_vout_freq_vin_config.sv
// Output scale, floor, switching rate and turn-on threshold command group
`timescale 1ns/100ps

// Functional notes
// - Word read and write by command code
// - In-range scale values stored and read unchanged
// - Divider chosen from decoded scale value
// - Reference scaling uses programmed scale value
// - Out-of-range writes rejected, flagged, alert raised
// - Floor is 16-bit unsigned absolute word
// - Target below floor warns, clamps to floor while converting
// - Floor violation sets status bits, alerts
// - Floor valid range equals ceiling range
// - Rate applies now if off, else deferred
// - Rate word is linear exponent and mantissa
// - Rate exponent generated from stored rate
// - Rate quantized into twelve supported bands
// - Turn-on word fixed exponent minus two
// - Turn-on writes apply at once, stored
// - Turn-on rounds down to hardware level
// - Low-input fault masked until first turn-on
// - Scale exponent resets fixed, mantissa from store
module pmbus_vout_freq_vin_config #(
   parameter logic [15:0] FLOOR_VALID_MIN = 16'h0000,
   parameter logic [15:0] FLOOR_VALID_MAX = 16'h2C00,
   parameter logic [47:0] SCALE_VALID_MIN = 48'h0000_0000_0001,
   parameter logic [47:0] SCALE_VALID_MAX = 48'h0000_0001_0000,
   parameter logic [10:0] TURN_ON_VALID_MIN_QV = 11'd10,
   parameter logic [10:0] TURN_ON_VALID_MAX_QV = 11'd72
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Command port
   input wire logic cmd_valid_in,
   input wire cfg_group_pkg::cmd_req_t cmd_req_in,
   output cfg_group_pkg::cmd_rsp_t cmd_rsp_out,
   // Stored configuration
   input wire cfg_group_pkg::nvm_cfg_t nvm_cfg_in,
   input wire logic nvm_restore_in,
   output logic nvm_store_req_out,
   output logic [15:0] nvm_store_word_out,
   // Conversion state and supply
   input wire logic conv_enable_in,
   input wire logic bias_uvlo_in,
   input wire logic vin_above_on_in,
   input wire logic low_input_raw_in,
   // Output target
   input wire logic target_change_in,
   input wire logic [15:0] target_req_in,
   output logic [15:0] target_out,
   // Hardware settings
   output logic [1:0] div_sel_out,
   output logic [23:0] vref_scale_out,
   output logic [3:0] rate_band_out,
   output logic [10:0] rate_khz_out,
   output logic [5:0] turn_on_qv_out,
   output logic low_input_fault_out,
   // Status
   input wire logic clear_faults_in,
   output cfg_group_pkg::status_t status_out,
   output logic alert_n_out
);
   import cfg_group_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // State
   logic [15:0] floor_q, scale_q, rate_q, turn_on_q, pend_scale_q, pend_rate_q;
   logic load_q, armed_q, set_invalid_cmd, set_invalid_data, set_floor_warn, wr, rd;
   logic [2:0] pin_meta_q, pin_sync_q;
   logic [15:0] rd_data;
   logic rd_hit;
   logic signed [47:0] wfix;
   logic [15:0] wkhz;
   logic w_scale_ok, w_rate_ok, w_floor_ok, w_turn_on_ok;
   logic [15:0] nvm_rate_word, nvm_scale_word, nvm_turn_on_word;
   logic signed [47:0] hw_scale_fix, hw_rate_fix;
   logic [15:0] hw_khz;
   logic [3:0] q_band;
   logic [10:0] q_khz;
   logic [7:0] sb_q, sv_q, sc_q;
   logic sw_vout_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Write checks
   assign wr = cmd_valid_in && cmd_req_in.write;
   assign rd = cmd_valid_in && !cmd_req_in.write;
   assign wfix = lin_fix(cmd_req_in.data);
   assign wkhz = wfix[FIX_FRAC+15:FIX_FRAC];
   assign w_scale_ok = (wfix >= $signed(SCALE_VALID_MIN))
      && (wfix <= $signed(SCALE_VALID_MAX));
   assign w_rate_ok = (wfix > 48'sh0) && (wfix[47:FIX_FRAC+16] == 16'h0000)
      && (wkhz < RATE_LIMIT_KHZ);
   assign w_floor_ok = (cmd_req_in.data >= FLOOR_VALID_MIN)
      && (cmd_req_in.data <= FLOOR_VALID_MAX);
   assign w_turn_on_ok = (cmd_req_in.data[EXP_MSB:EXP_LSB] == TURN_ON_EXP_RESET)
      && (cmd_req_in.data[MAN_MSB:MAN_LSB] >= TURN_ON_VALID_MIN_QV)
      && (cmd_req_in.data[MAN_MSB:MAN_LSB] <= TURN_ON_VALID_MAX_QV);

   always_comb begin
      set_invalid_cmd = 1'b0;
      set_invalid_data = 1'b0;
      if (cmd_valid_in) begin
         case (cmd_req_in.code)
            CMD_SCALE_LOOP: set_invalid_data = wr && !w_scale_ok;
            CMD_OUTPUT_FLOOR: set_invalid_data = wr && !w_floor_ok;
            CMD_SWITCHING_RATE: set_invalid_data = wr && !w_rate_ok;
            CMD_INPUT_TURN_ON: set_invalid_data = wr && !w_turn_on_ok;
            default: set_invalid_cmd = 1'b1;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stored configuration words
   // Exponent zero while the rate fits the positive mantissa, else one
   assign nvm_rate_word = (nvm_cfg_in.rate_khz > MAN_POS_MAX) ?
      {5'h01, 1'b0, nvm_cfg_in.rate_khz[10:1]} :
      {5'h00, nvm_cfg_in.rate_khz};
   assign nvm_scale_word = {SCALE_EXP_RESET, nvm_cfg_in.scale_man};
   assign nvm_turn_on_word = {TURN_ON_EXP_RESET, nvm_cfg_in.turn_on_man};

   // Registers, loaded one cycle after reset release and on restore
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         load_q <= 1'b1;
         floor_q <= WORD_RESET;
         scale_q <= {SCALE_EXP_RESET, 11'h000};
         rate_q <= WORD_RESET;
         turn_on_q <= {TURN_ON_EXP_RESET, 11'h000};
      end else begin
         load_q <= 1'b0;
         if (load_q || nvm_restore_in) begin
            floor_q <= nvm_cfg_in.floor_word;
            scale_q <= nvm_scale_word;
            rate_q <= nvm_rate_word;
            turn_on_q <= nvm_turn_on_word;
         end else if (wr && !set_invalid_data) begin
            case (cmd_req_in.code)
               CMD_SCALE_LOOP: scale_q <= cmd_req_in.data;
               CMD_OUTPUT_FLOOR: floor_q <= cmd_req_in.data;
               CMD_SWITCHING_RATE: rate_q <= cmd_req_in.data;
               CMD_INPUT_TURN_ON: turn_on_q <= cmd_req_in.data;
               default: floor_q <= floor_q;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read answers
   always_comb begin
      rd_hit = 1'b1;
      case (cmd_req_in.code)
         CMD_SCALE_LOOP: rd_data = scale_q;
         CMD_OUTPUT_FLOOR: rd_data = floor_q;
         CMD_SWITCHING_RATE: rd_data = rate_q;
         CMD_INPUT_TURN_ON: rd_data = turn_on_q;
         default: begin
            rd_data = 16'h0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cmd_rsp_out <= '0;
      end else begin
         cmd_rsp_out.valid <= cmd_valid_in;
         cmd_rsp_out.error <= set_invalid_cmd || set_invalid_data;
         cmd_rsp_out.data <= (rd && rd_hit) ? rd_data : 16'h0000;
      end
   end

   // Each accepted write is handed to the backing store
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         nvm_store_req_out <= 1'b0;
         nvm_store_word_out <= 16'h0000;
      end else begin
         nvm_store_req_out <= wr && !set_invalid_cmd && !set_invalid_data;
         nvm_store_word_out <= cmd_req_in.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Deferred hardware update for scale and rate
   // Words accepted while converting wait here; the hardware sees a divider or
   // rate change under load only from a restore, which applies at once, or from the synced bias_uvlo_in flag
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pend_scale_q <= {SCALE_EXP_RESET, 11'h000};
         pend_rate_q <= WORD_RESET;
      end else if (load_q || nvm_restore_in) begin
         pend_scale_q <= nvm_scale_word;
         pend_rate_q <= nvm_rate_word;
      end else if (wr && !set_invalid_data && !conv_enable_in) begin
         if (cmd_req_in.code == CMD_SCALE_LOOP) begin
            pend_scale_q <= cmd_req_in.data;
         end
         if (cmd_req_in.code == CMD_SWITCHING_RATE) begin
            pend_rate_q <= cmd_req_in.data;
         end
      end else if (pin_sync_q[0]) begin
         pend_scale_q <= scale_q;
         pend_rate_q <= rate_q;
      end
   end

   assign hw_scale_fix = lin_fix(pend_scale_q);
   assign hw_rate_fix = lin_fix(pend_rate_q);
   assign hw_khz = hw_rate_fix[FIX_FRAC+15:FIX_FRAC];
   rate_quantizer u_rate_quantizer (
      .khz_in(hw_khz),
      .band_out(q_band),
      .eff_khz_out(q_khz)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Hardware settings
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         div_sel_out <= DIV_ONE;
         vref_scale_out <= 24'h000000;
         rate_band_out <= 4'h0;
         rate_khz_out <= RATE_BAND_KHZ[0];
         turn_on_qv_out <= TURN_ON_HW_MIN_QV[5:0];
      end else begin
         if (hw_scale_fix <= $signed(FIX_EIGHTH)) begin
            div_sel_out <= DIV_EIGHTH;
         end else if (hw_scale_fix <= $signed(FIX_QUARTER)) begin
            div_sel_out <= DIV_QUARTER;
         end else if (hw_scale_fix <= $signed(FIX_HALF)) begin
            div_sel_out <= DIV_HALF;
         end else begin
            div_sel_out <= DIV_ONE;
         end
         // Programmed value, not the divider step, so command and output may differ
         vref_scale_out <= (hw_scale_fix > $signed(FIX_ONE)) ? 24'h010000 :
            hw_scale_fix[23:0];
         rate_band_out <= q_band;
         rate_khz_out <= q_khz;
         // Mantissa is quarter volts; clamp is the round-down to a real level
         if (turn_on_q[MAN_MSB:MAN_LSB] > TURN_ON_HW_MAX_QV) begin
            turn_on_qv_out <= TURN_ON_HW_MAX_QV[5:0];
         end else if (turn_on_q[MAN_MSB:MAN_LSB] < TURN_ON_HW_MIN_QV) begin
            turn_on_qv_out <= TURN_ON_HW_MIN_QV[5:0];
         end else begin
            turn_on_qv_out <= turn_on_q[5:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Output floor enforcement
   assign set_floor_warn = target_change_in && conv_enable_in
      && (target_req_in < floor_q);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         target_out <= 16'h0000;
      end else if (target_change_in) begin
         // Slewing to this target is done by the transition-rate logic downstream
         target_out <= set_floor_warn ? floor_q : target_req_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparator and supply flags are unclocked; two stages before any use
   always_ff @(posedge sys_clk_in) begin
      pin_meta_q <= {vin_above_on_in, low_input_raw_in, bias_uvlo_in};
      pin_sync_q <= pin_meta_q;
   end

   // Low-input fault mask, cleared only by reset
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         armed_q <= 1'b0;
         low_input_fault_out <= 1'b0;
      end else begin
         if (pin_sync_q[2]) begin
            armed_q <= 1'b1;
         end
         low_input_fault_out <= armed_q && pin_sync_q[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sticky status; a set in the clearing cycle wins
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         sb_q <= 8'h00;
         sv_q <= 8'h00;
         sc_q <= 8'h00;
         sw_vout_q <= 1'b0;
      end else begin
         if (clear_faults_in) begin
            sb_q <= 8'h00;
            sv_q <= 8'h00;
            sc_q <= 8'h00;
            sw_vout_q <= 1'b0;
         end
         if (set_floor_warn) begin
            sb_q[SB_NONE_ABOVE] <= 1'b1;
            sw_vout_q <= 1'b1;
            sv_q[SV_MAX_MIN_WARN] <= 1'b1;
         end
         if (set_invalid_data) begin
            sc_q[SC_INVALID_DATA] <= 1'b1;
            sb_q[SB_CML] <= 1'b1;
         end
         if (set_invalid_cmd) begin
            sc_q[SC_INVALID_CMD] <= 1'b1;
            sb_q[SB_CML] <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         status_out <= '0;
         alert_n_out <= 1'b1;
      end else begin
         status_out.status_byte <= sb_q;
         status_out.status_word <= {sw_vout_q, 7'h00, sb_q};
         status_out.status_vout <= sv_q;
         status_out.status_cml <= sc_q;
         alert_n_out <= !((|sb_q) || sw_vout_q);
      end
   end

endmodule : pmbus_vout_freq_vin_config

// >>> rtl/rate_quantizer.sv
// Maps a requested switching rate in kHz onto a supported band
`timescale 1ns/100ps
module rate_quantizer (
   // Request
   input wire logic [15:0] khz_in,
   // Result
   output logic [3:0] band_out,
   output logic [10:0] eff_khz_out
);
   import cfg_group_pkg::*;

   always_comb begin
      band_out = 4'h0;
      for (int i = 0; i < RATE_BANDS - 1; i++) begin
         if (khz_in >= {5'h00, RATE_BAND_START[i]}) begin
            band_out = 4'(i + 1);
         end
      end
      eff_khz_out = RATE_BAND_KHZ[band_out];
   end

endmodule : rate_quantizer

// >>> sim/cfg_group_monitor.sv
// Checker for the config command group, bound to its top module
`timescale 1ns/100ps
module cfg_group_monitor (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Command port
   input wire logic cmd_valid_in,
   input wire cfg_group_pkg::cmd_req_t cmd_req_in,
   input wire cfg_group_pkg::cmd_rsp_t cmd_rsp_out,
   input wire logic nvm_store_req_out,
   // Target and hardware
   input wire logic conv_enable_in,
   input wire logic low_input_raw_in,
   input wire logic target_change_in,
   input wire logic [15:0] target_req_in,
   input wire logic [15:0] target_out,
   input wire logic [1:0] div_sel_out,
   input wire logic [23:0] vref_scale_out,
   input wire logic [3:0] rate_band_out,
   input wire logic [10:0] rate_khz_out,
   input wire logic [5:0] turn_on_qv_out,
   input wire logic low_input_fault_out,
   // Status
   input wire cfg_group_pkg::status_t status_out,
   input wire logic alert_n_out
);
   import cfg_group_pkg::*;
   cmd_req_t req_q;
   cmd_req_t req_qq;
   // Two-deep copy of the request, so the turn-on check sees the word two cycles on
   always_ff @(posedge sys_clk_in) begin
      req_q <= cmd_req_in;
      req_qq <= req_q;
   end
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   ////////////////////////////////////////////////////////////////////////////////
   a_rsp_next_cycle: assert property (cmd_valid_in |=> cmd_rsp_out.valid)
      else $error("Command not answered one cycle later");
   a_store_on_accept: assert property (
      nvm_store_req_out |-> cmd_rsp_out.valid && !cmd_rsp_out.error)
      else $error("Store request without accepted write");
   a_read_no_store: assert property (
      cmd_valid_in && !cmd_req_in.write |=> !nvm_store_req_out)
      else $error("Read caused a store request");
   a_target_pass: assert property (
      target_change_in && !conv_enable_in |=> target_out == $past(target_req_in))
      else $error("Target altered while conversion off");
   a_target_floor: assert property (
      target_change_in && conv_enable_in |=> target_out >= $past(target_req_in))
      else $error("Target went below request");
   a_floor_warns: assert property (
      target_change_in && conv_enable_in ##1 target_out != $past(target_req_in)
      |=> status_out.status_vout[SV_MAX_MIN_WARN] && status_out.status_word[SW_VOUT]
      && status_out.status_byte[SB_NONE_ABOVE] && !alert_n_out)
      else $error("Floor clamp without warning status");
   a_div_match: assert property ($changed(vref_scale_out) |-> div_sel_out ==
      (vref_scale_out <= 24'h002000 ? DIV_EIGHTH : vref_scale_out <= 24'h004000 ?
      DIV_QUARTER : vref_scale_out <= 24'h008000 ? DIV_HALF : DIV_ONE))
      else $error("Divider does not match scale value");
   a_band_rate: assert property (
      rate_khz_out == RATE_BAND_KHZ[rate_band_out])
      else $error("Effective rate does not match band");
   a_turn_on_apply: assert property (
      cmd_valid_in && cmd_req_in.write && cmd_req_in.code == CMD_INPUT_TURN_ON
      ##1 cmd_rsp_out.valid && !cmd_rsp_out.error |=> turn_on_qv_out ==
      (req_qq.data[10:0] > 11'h03F ? 6'h3F : req_qq.data[5:0]))
      else $error("Turn-on level not applied");
   a_fault_masked: assert property (
      low_input_fault_out |-> $past(low_input_raw_in, 3))
      else $error("Low input fault without raw fault");
   c_clamp: cover property (target_change_in && conv_enable_in ##1
      target_out != $past(target_req_in));
   c_refused: cover property (cmd_valid_in && cmd_req_in.write ##1 cmd_rsp_out.error);
   c_fault: cover property ($rose(low_input_fault_out));
endmodule : cfg_group_monitor

bind pmbus_vout_freq_vin_config cfg_group_monitor u_mon (
   .sys_clk_in, .rst_in, .cmd_valid_in, .cmd_req_in, .cmd_rsp_out, .nvm_store_req_out,
   .conv_enable_in, .low_input_raw_in, .target_change_in, .target_req_in, .target_out,
   .div_sel_out, .vref_scale_out, .rate_band_out, .rate_khz_out, .turn_on_qv_out,
   .low_input_fault_out, .status_out, .alert_n_out);

// >>> sim/pmbus_host_model.sv
// Host model that issues word commands on the command port
`timescale 1ns/100ps
module pmbus_host_model (
   // Clock
   input wire logic sys_clk_in,
   // Command port
   output logic cmd_valid_out,
   output cfg_group_pkg::cmd_req_t cmd_req_out,
   input wire cfg_group_pkg::cmd_rsp_t cmd_rsp_in
);
   import cfg_group_pkg::*;
   initial begin
      cmd_valid_out = 1'h0;
      cmd_req_out = '0;
   end
   // One word per command, answer taken one cycle after the request
   task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
         output cmd_rsp_t rsp);
      @(negedge sys_clk_in);
      cmd_req_out = {wr, code, data};
      cmd_valid_out = 1'h1;
      @(negedge sys_clk_in);
      cmd_valid_out = 1'h0;
      rsp = cmd_rsp_in;
      // Idle request lines flip so a stale word is never mistaken for a new one
      cmd_req_out = ~cmd_req_out;
   endtask : xfer
endmodule : pmbus_host_model

// >>> sim/testbench.sv
// Testbench for the output scale, floor, rate and turn-on command group
`timescale 1ns/100ps
module testbench;
   import cfg_group_pkg::*;
   logic sys_clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic cmd_valid_in, nvm_restore_in = 1'h0, conv_enable_in = 1'h0, bias_uvlo_in = 1'h0;
   logic vin_above_on_in = 1'h0, low_input_raw_in = 1'h0, target_change_in = 1'h0;
   logic clear_faults_in = 1'h0, nvm_store_req_out, low_input_fault_out, alert_n_out;
   logic [15:0] target_req_in = 16'h0000, nvm_store_word_out, target_out;
   logic [1:0] div_sel_out;
   logic [23:0] vref_scale_out;
   logic [3:0] rate_band_out;
   logic [10:0] rate_khz_out;
   logic [5:0] turn_on_qv_out;
   cmd_req_t cmd_req_in;
   cmd_rsp_t cmd_rsp_out, rsp;
   status_t status_out;
   nvm_cfg_t nvm_cfg_in = '{16'h0400, 11'h040, 11'h1F4, 11'h028};
   logic [10:0] sc_man [7] = '{11'h010, 11'h011, 11'h020, 11'h021, 11'h040, 11'h041, 11'h080};
   logic [1:0] sc_div [7] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
   logic [15:0] fr_word [12] = '{16'h00FA, 16'h012C, 16'h015E, 16'h019A, 16'h01F4,
      16'h0258, 16'h02BC, 16'h0334, 16'h03E8, 16'h0A58, 16'h0ABC, 16'h0B38};
   int num_errors = 0, n_checks = 0, cyc = 0;

   always #2.5 sys_clk_in = ~sys_clk_in;

   pmbus_vout_freq_vin_config u_dut (.sys_clk_in, .rst_in, .cmd_valid_in, .cmd_req_in,
      .cmd_rsp_out, .nvm_cfg_in, .nvm_restore_in, .nvm_store_req_out, .nvm_store_word_out,
      .conv_enable_in, .bias_uvlo_in, .vin_above_on_in, .low_input_raw_in,
      .target_change_in, .target_req_in, .target_out, .div_sel_out, .vref_scale_out,
      .rate_band_out, .rate_khz_out, .turn_on_qv_out, .low_input_fault_out,
      .clear_faults_in, .status_out, .alert_n_out);
   pmbus_host_model u_host (.sys_clk_in, .cmd_valid_out(cmd_valid_in),
      .cmd_req_out(cmd_req_in), .cmd_rsp_in(cmd_rsp_out));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("Checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic step(input int n);
      repeat (n) @(negedge sys_clk_in);
   endtask : step

   task automatic pulse(ref logic s);
      @(negedge sys_clk_in);
      s = 1'h1;
      @(negedge sys_clk_in);
      s = 1'h0;
   endtask : pulse

   task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic err);
      u_host.xfer(1'h1, c, d, rsp);
      chk({rsp.valid, rsp.error, nvm_store_req_out}, {1'h1, err, !err});
      if (!err) chk(nvm_store_word_out, d);
   endtask : wr

   task automatic rd(input logic [7:0] c, input logic [15:0] d);
      u_host.xfer(1'h0, c, 16'h0000, rsp);
      chk({rsp.valid, rsp.error, rsp.data}, {2'h2, d});
   endtask : rd

   task automatic tgt(input logic [15:0] d, input logic [15:0] e);
      target_req_in = d;
      pulse(target_change_in);
      chk(target_out, e);
   endtask : tgt

   // Hang guard: the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      step(20);
      rst_in = 1'h0;
      step(3);
      rd(CMD_OUTPUT_FLOOR, 16'h0400);
      rd(CMD_SCALE_LOOP, 16'hC840);
      rd(CMD_SWITCHING_RATE, 16'h01F4);
      rd(CMD_INPUT_TURN_ON, 16'hF028);
      chk({div_sel_out, vref_scale_out}, {2'h2, 24'h008000});
      chk({rate_band_out, rate_khz_out, turn_on_qv_out}, {4'h4, 11'h1C2, 6'h28});
      $display("Section reset load done");
      foreach (sc_man[i]) begin
         wr(CMD_SCALE_LOOP, {5'h19, sc_man[i]}, 1'h0);
         step(2);
         rd(CMD_SCALE_LOOP, {5'h19, sc_man[i]});
         chk({div_sel_out, vref_scale_out}, {sc_div[i], 4'h0, sc_man[i], 9'h000});
      end
      wr(CMD_SCALE_LOOP, 16'hC800, 1'h1);
      wr(CMD_SCALE_LOOP, {5'h19, 11'h100}, 1'h1);
      rd(CMD_SCALE_LOOP, 16'hC880);
      $display("Section scale done");
      // Rates above 1100 kHz are only sent here, with conversion off
      foreach (fr_word[i]) begin
         wr(CMD_SWITCHING_RATE, fr_word[i], 1'h0);
         step(2);
         chk({rate_band_out, rate_khz_out}, {4'(i), RATE_BAND_KHZ[i]});
      end
      wr(CMD_SWITCHING_RATE, 16'h0B39, 1'h1);
      wr(CMD_SWITCHING_RATE, 16'h0000, 1'h1);
      conv_enable_in = 1'h1;
      wr(CMD_SWITCHING_RATE, 16'h01F4, 1'h0);
      step(3);
      chk(rate_band_out, 4'hB);
      pulse(bias_uvlo_in);
      step(3);
      chk({rate_band_out, rate_khz_out}, {4'h4, 11'h1C2});
      wr(CMD_SWITCHING_RATE, 16'h03E8, 1'h0);
      wr(CMD_SCALE_LOOP, 16'hC810, 1'h0);
      step(3);
      chk({rate_band_out, div_sel_out}, {4'h4, 2'h3});
      pulse(nvm_restore_in);
      step(3);
      rd(CMD_SCALE_LOOP, 16'hC840);
      chk({div_sel_out, vref_scale_out}, {2'h2, 24'h008000});
      wr(CMD_INPUT_TURN_ON, 16'hF048, 1'h0);
      step(2);
      chk(turn_on_qv_out, 6'h3F);
      conv_enable_in = 1'h0;
      $display("Section rate done");
      wr(CMD_OUTPUT_FLOOR, 16'h2C01, 1'h1);
      wr(CMD_OUTPUT_FLOOR, 16'h2C00, 1'h0);
      rd(CMD_OUTPUT_FLOOR, 16'h2C00);
      wr(CMD_INPUT_TURN_ON, 16'h0028, 1'h1);
      wr(CMD_INPUT_TURN_ON, 16'hF009, 1'h1);
      wr(CMD_INPUT_TURN_ON, 16'hF049, 1'h1);
      wr(8'h30, 16'h1234, 1'h1);
      wr(CMD_INPUT_TURN_ON, 16'hF02B, 1'h0);
      step(1);
      chk({status_out.status_byte[1], status_out.status_cml[7:6], alert_n_out,
         turn_on_qv_out}, {4'hE, 6'h2B});
      pulse(clear_faults_in);
      step(2);
      chk(alert_n_out, 1'h1);
      $display("Section refusal done");
      wr(CMD_OUTPUT_FLOOR, 16'h0400, 1'h0);
      conv_enable_in = 1'h1;
      tgt(16'h0500, 16'h0500);
      tgt(16'h0300, 16'h0400);
      step(1);
      chk({status_out.status_byte[0], status_out.status_word[15], status_out.status_vout[3],
         alert_n_out}, 4'hE);
      pulse(clear_faults_in);
      conv_enable_in = 1'h0;
      tgt(16'h0300, 16'h0300);
      step(2);
      chk(alert_n_out, 1'h1);
      $display("Section floor done");
      low_input_raw_in = 1'h1;
      step(3);
      chk(low_input_fault_out, 1'h0);
      pulse(vin_above_on_in);
      step(3);
      chk(low_input_fault_out, 1'h1);
      pulse(nvm_restore_in);
      pulse(conv_enable_in);
      step(3);
      chk(low_input_fault_out, 1'h1);
      low_input_raw_in = 1'h0;
      $display("Section low input done");
      test_done();
   end
endmodule : testbench
